//--- trt_defines.svh
// Constants for the tape reader start-stop transmitter.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef TRT_DEFINES_SVH
`define TRT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Code group layout
// ----------------------------------------------------------------------------
`define TRT_CODE_BITS 5
`define TRT_LAST_BIT 3'H4
`define TRT_FIRST_BIT 3'H0
`define TRT_MARK 1'B1
`define TRT_SPACE 1'B0

// ----------------------------------------------------------------------------
// Timing and buffer depth
// ----------------------------------------------------------------------------
`define TRT_CLK_PERIOD_NS 4
`define TRT_UNIT_NS 4000
`define TRT_UNIT_CYCLES (`TRT_UNIT_NS / `TRT_CLK_PERIOD_NS)
`define TRT_STOP_UNITS 1
`define TRT_FIFO_DEPTH 16

`endif

//--- trt_pkg.sv
// Types shared by the tape reader start-stop transmitter.
// Assumes trt_defines.svh is on the include path.
`include "trt_defines.svh"

package trt_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        TRT_IDLE = 4'H1,
        TRT_START = 4'H2,
        TRT_DATA = 4'H4,
        TRT_STOP = 4'H8
    } trt_state_t;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef logic [`TRT_CODE_BITS-1:0] trt_row_t;

    typedef struct packed {
        logic start;
        logic tape_out;
        logic tight_tape;
        logic manual_stop;
    } trt_ctl_t;

    typedef struct packed {
        trt_ctl_t ctl_m;
        trt_ctl_t ctl_s;
        trt_row_t row_m;
        trt_row_t row_s;
        trt_state_t state;
        trt_row_t row;
        logic [2:0] bit_idx;
        logic [3:0] stop_cnt;
        logic line;
        logic adv;
        logic busy;
        logic push;
        trt_row_t push_code;
    } trt_tx_st_t;

endpackage

//--- trt_baud.sv
// Unit interval divider for the tape reader transmitter.
// Assumes one clock; clr restarts a full unit from the next edge.
`timescale 1ns/10ps

module trt_baud #(
    parameter int unsigned CYCLES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic clr,
    output logic tick
);
    localparam int unsigned CW = (CYCLES > 2) ? $clog2(CYCLES) : 2;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } trt_baud_st_t;

    trt_baud_st_t q;
    trt_baud_st_t d;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // A clear loads one so that the first tick lands exactly one unit later.
    always_comb begin
        d = q;
        d.tick = 1'B0;
        if (clr) begin
            d.cnt = ONE;
        end else if (q.cnt == LAST) begin
            d.cnt = '0;
            d.tick = 1'B1;
        end else begin
            d.cnt = q.cnt + ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule // trt_baud

//--- trt_fifo.sv
// Small FIFO memory with a registered read stage.
// Assumes one clock; valid and ready handshake on both sides.
`timescale 1ns/10ps

module trt_fifo #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] STEP = (AW+1)'(1);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } trt_fifo_st_t;

    trt_fifo_st_t q;
    trt_fifo_st_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic load;

    // ------------------------------------------------------------------------
    // Pointers and read register
    // ------------------------------------------------------------------------
    assign in_ready = (q.wr - q.rd) != FULL;
    assign push = in_valid && in_ready;
    assign load = (q.wr != q.rd) && (!q.out_valid || out_ready);

    always_comb begin
        d = q;
        if (push) begin
            d.wr = q.wr + STEP;
        end
        if (load) begin
            d.out_data = mem[q.rd[AW-1:0]];
            d.out_valid = 1'B1;
            d.rd = q.rd + STEP;
        end else if (out_ready) begin
            d.out_valid = 1'B0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[q.wr[AW-1:0]] <= in_data;
        end
    end

    assign out_valid = q.out_valid;
    assign out_data = q.out_data;

endmodule // trt_fifo

//--- trt_transmitter.sv
// Start-stop serial transmitter fed by a five-hole tape reader.
// Assumes asynchronous control and sense pins, a synchronous consumer of the
// sent-code stream and a reader that moves the tape on each advance pulse.
`timescale 1ns/10ps
`include "trt_defines.svh"

module trt_transmitter #(
    parameter int unsigned UNIT_CYCLES = `TRT_UNIT_CYCLES,
    parameter int unsigned STOP_UNITS = `TRT_STOP_UNITS,
    parameter int unsigned FIFO_DEPTH = `TRT_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Operator and reader control pins
    input wire logic START_REQ,
    input wire logic TAPE_OUT,
    input wire logic TIGHT_TAPE,
    input wire logic MANUAL_STOP,
    // Tape sense pins, one per code position
    input wire logic [`TRT_CODE_BITS-1:0] TAPE_ROW,
    // Signal line and reader feed
    output logic LINE_MARK,
    output logic TAPE_ADVANCE,
    output logic BUSY,
    // Stream of sent code groups
    output logic SENT_VALID,
    input wire logic SENT_READY,
    output logic [`TRT_CODE_BITS-1:0] SENT_CODE
);
    localparam logic [3:0] STOP_LAST = 4'(STOP_UNITS - 1);

    trt_pkg::trt_tx_st_t q;
    trt_pkg::trt_tx_st_t d;
    trt_pkg::trt_ctl_t ctl_pins;
    logic tick;
    logic clr;
    logic run;
    logic go;
    logic fifo_in_ready;

    function automatic logic slot_level(input trt_pkg::trt_state_t st,
                                        input trt_pkg::trt_row_t row,
                                        input logic [2:0] idx);
        logic lvl;
        lvl = `TRT_MARK;
        if (st == trt_pkg::TRT_START) begin
            lvl = `TRT_SPACE;
        end else if (st == trt_pkg::TRT_DATA) begin
            lvl = row[idx];
        end
        return lvl;
    endfunction

    // ------------------------------------------------------------------------
    // Unit interval divider
    // ------------------------------------------------------------------------
    trt_baud #(
        .CYCLES(UNIT_CYCLES)
    ) u_baud (
        .clk(MCLK),
        .rst(RESET),
        .clr(clr),
        .tick(tick)
    );

    // ------------------------------------------------------------------------
    // Sent-code buffer
    // ------------------------------------------------------------------------
    // A full buffer holds the next group back, so a stalled consumer stops
    // the tape rather than losing a code.
    trt_fifo #(
        .WIDTH(`TRT_CODE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst(RESET),
        .in_valid(q.push),
        .in_ready(fifo_in_ready),
        .in_data(q.push_code),
        .out_valid(SENT_VALID),
        .out_ready(SENT_READY),
        .out_data(SENT_CODE)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    assign ctl_pins = '{start: START_REQ, tape_out: TAPE_OUT,
                        tight_tape: TIGHT_TAPE, manual_stop: MANUAL_STOP};

    // Any stop condition withdraws the start control.
    assign run = q.ctl_s.start && !q.ctl_s.tape_out && !q.ctl_s.tight_tape
                 && !q.ctl_s.manual_stop;
    assign go = run && fifo_in_ready;

    always_comb begin
        d = q;
        clr = 1'B0;
        d.ctl_m = ctl_pins;
        d.ctl_s = q.ctl_m;
        d.row_m = TAPE_ROW;
        d.row_s = q.row_m;
        d.adv = 1'B0;
        d.push = 1'B0;
        unique case (q.state)
            trt_pkg::TRT_IDLE: begin
                if (go) begin
                    d.state = trt_pkg::TRT_START;
                    d.row = q.row_s;
                    clr = 1'B1;
                end
            end
            trt_pkg::TRT_START: begin
                if (tick) begin
                    d.state = trt_pkg::TRT_DATA;
                    d.bit_idx = `TRT_FIRST_BIT;
                end
            end
            trt_pkg::TRT_DATA: begin
                if (tick) begin
                    if (q.bit_idx == `TRT_LAST_BIT) begin
                        d.state = trt_pkg::TRT_STOP;
                        d.stop_cnt = '0;
                        d.adv = 1'B1;
                        d.push = 1'B1;
                        d.push_code = q.row;
                    end else begin
                        d.bit_idx = q.bit_idx + 3'H1;
                    end
                end
            end
            trt_pkg::TRT_STOP: begin
                if (tick) begin
                    if (q.stop_cnt == STOP_LAST) begin
                        if (go) begin
                            d.state = trt_pkg::TRT_START;
                            d.row = q.row_s;
                            clr = 1'B1;
                        end else begin
                            d.state = trt_pkg::TRT_IDLE;
                        end
                    end else begin
                        d.stop_cnt = q.stop_cnt + 4'H1;
                    end
                end
            end
        endcase
        // Each slot is chosen only by its own position bit.
        d.line = slot_level(d.state, d.row, d.bit_idx);
        d.busy = d.state != trt_pkg::TRT_IDLE;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            q <= '0;
            q.state <= trt_pkg::TRT_IDLE;
            q.line <= `TRT_MARK;
        end else begin
            q <= d;
        end
    end

    assign LINE_MARK = q.line;
    assign TAPE_ADVANCE = q.adv;
    assign BUSY = q.busy;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Counts the cycles spent in the current start impulse.
    logic [31:0] start_len_q;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            start_len_q <= 32'H0;
        end else if (d.state == trt_pkg::TRT_START && clr) begin
            start_len_q <= 32'H1;
        end else if (q.state == trt_pkg::TRT_START) begin
            start_len_q <= start_len_q + 32'H1;
        end
    end

    // Counts the cycles spent in the current code slot or stop impulse.
    logic [31:0] slot_len_q;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            slot_len_q <= 32'H0;
        end else if (d.state != q.state || d.bit_idx != q.bit_idx) begin
            slot_len_q <= 32'H1;
        end else begin
            slot_len_q <= slot_len_q + 32'H1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    AST_IDLE_MARK: assert property (
        q.state == trt_pkg::TRT_IDLE |-> LINE_MARK == `TRT_MARK)
        else $error("Line not marking while idle.");

    AST_START_SPACE: assert property (
        $changed(q.state) && q.state == trt_pkg::TRT_START
        |-> LINE_MARK == `TRT_SPACE && $past(LINE_MARK) == `TRT_MARK)
        else $error("Group did not open with a spacing start impulse.");

    AST_SLOT_LEVEL: assert property (
        q.state == trt_pkg::TRT_DATA |-> LINE_MARK == q.row[q.bit_idx])
        else $error("Code impulse does not match the sensed position.");

    AST_NO_HOLE_SPACE: assert property (
        q.state == trt_pkg::TRT_DATA && !q.row[q.bit_idx] |-> !LINE_MARK)
        else $error("Unpunched position sent as marking.");

    AST_BIT_ORDER: assert property (
        q.state == trt_pkg::TRT_DATA && tick && q.bit_idx != `TRT_LAST_BIT
        |=> q.state == trt_pkg::TRT_DATA && q.bit_idx == $past(q.bit_idx) + 3'H1)
        else $error("Code slots out of order.");

    AST_ONE_STATE: assert property (
        $onehot(q.state))
        else $error("Sequencer state not one-hot.");

    AST_ROW_HOLD: assert property (
        q.state == trt_pkg::TRT_DATA || q.state == trt_pkg::TRT_STOP
        |-> $stable(q.row))
        else $error("Sampled row changed within a group.");

    AST_START_RUN: assert property (
        q.state == trt_pkg::TRT_IDLE && run && fifo_in_ready
        |=> q.state == trt_pkg::TRT_START)
        else $error("Start control did not begin a group.");

    AST_HALT: assert property (
        q.state == trt_pkg::TRT_IDLE && !run |=> q.state == trt_pkg::TRT_IDLE)
        else $error("Group began without start control.");

    AST_ADVANCE: assert property (
        TAPE_ADVANCE |-> q.state == trt_pkg::TRT_STOP
        && $past(q.state) == trt_pkg::TRT_DATA && $past(q.bit_idx) == `TRT_LAST_BIT)
        else $error("Advance not issued right after the fifth code impulse.");

    AST_ONE_ROW: assert property (
        TAPE_ADVANCE |=> !TAPE_ADVANCE [*2])
        else $error("Advance longer than one pulse.");

    AST_UNIT_LEN: assert property (
        q.state == trt_pkg::TRT_START && tick |-> start_len_q == UNIT_CYCLES)
        else $error("Start impulse not one unit long.");

    AST_BACK_TO_BACK: assert property (
        q.state == trt_pkg::TRT_STOP && tick && q.stop_cnt == STOP_LAST && go
        |=> q.state == trt_pkg::TRT_START && !LINE_MARK)
        else $error("Idle gap inserted between groups.");

    AST_SLOT_LEN: assert property (
        q.state == trt_pkg::TRT_DATA && tick |-> slot_len_q == UNIT_CYCLES)
        else $error("Code impulse not one unit long.");

    AST_STOP_LEN: assert property (
        q.state == trt_pkg::TRT_STOP && tick && q.stop_cnt == STOP_LAST
        |-> slot_len_q == STOP_UNITS * UNIT_CYCLES)
        else $error("Stop impulse not the set number of units.");

    AST_STOP_MARK: assert property (
        q.state == trt_pkg::TRT_STOP |-> LINE_MARK == `TRT_MARK)
        else $error("Stop impulse not marking.");

    AST_BUSY_LEVEL: assert property (
        BUSY == (q.state != trt_pkg::TRT_IDLE))
        else $error("Busy does not follow the group in progress.");

    AST_FULL_HOLD: assert property (
        q.state == trt_pkg::TRT_IDLE && !fifo_in_ready |=> q.state == trt_pkg::TRT_IDLE)
        else $error("Group began while the sent-code buffer was full.");

    COV_BACK_TO_BACK: cover property (
        q.state == trt_pkg::TRT_STOP ##1 q.state == trt_pkg::TRT_START);

    COV_STOP_MID_GROUP: cover property (
        q.state == trt_pkg::TRT_DATA && q.ctl_s.tape_out);

    COV_BUFFER_FULL: cover property (
        q.state == trt_pkg::TRT_IDLE && run && !fifo_in_ready);

    COV_ALL_MARKS: cover property (
        q.state == trt_pkg::TRT_DATA && q.row == 5'H1F);

    COV_STOP_CAUSE: cover property (
        q.state == trt_pkg::TRT_STOP && q.ctl_s.tight_tape);

endmodule // trt_transmitter

//--- trt_line_rx.sv
// Receiving unit model that decodes start-stop groups from the signal line.
// Assumes one clock; the line is sampled at falling edges, near mid-unit.
`timescale 1ns/10ps

module trt_line_rx #(
    parameter int unsigned UNIT = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Signal line
    input wire logic line,
    // Decoded groups
    output logic rx_valid,
    output logic [4:0] rx_code,
    output logic rx_ok,
    output logic in_code
);
    initial begin
        rx_valid = 1'B0;
        rx_code = 5'H00;
        rx_ok = 1'B0;
        in_code = 1'B0;
        forever begin
            @(negedge clk);
            if (!rst && line === 1'B0) begin
                repeat (UNIT / 2) @(negedge clk);
                rx_ok = (line === 1'B0);
                in_code = 1'B1;
                for (int i = 0; i < 5; i++) begin
                    repeat (UNIT) @(negedge clk);
                    rx_code[i] = line;
                end
                in_code = 1'B0;
                repeat (UNIT) @(negedge clk);
                rx_ok = rx_ok && (line === 1'B1);
                rx_valid = 1'B1;
                @(negedge clk);
                rx_valid = 1'B0;
            end
        end
    end
endmodule // trt_line_rx

//--- test_tape_reader_startstop_transmitter.sv
// Self-checking bench for the tape reader transmitter with a tape model.
// Assumes the receiving unit model decodes the line; rows are random.
`timescale 1ns/10ps
`include "trt_defines.svh"

module test_tape_reader_startstop_transmitter;
    localparam int unsigned U = 8;
    logic MCLK = 1'B0;
    logic RESET = 1'B1;
    logic START_REQ = 1'B0;
    logic TAPE_OUT = 1'B1;
    logic TIGHT_TAPE = 1'B0;
    logic MANUAL_STOP = 1'B0;
    logic [4:0] TAPE_ROW = 5'H00;
    logic SENT_READY = 1'B0;
    logic LINE_MARK, TAPE_ADVANCE, BUSY, SENT_VALID;
    logic [4:0] SENT_CODE;
    logic rx_valid, rx_ok, in_code;
    logic [4:0] rx_code;
    logic [4:0] tape_q[$];
    logic [4:0] exp_q[$];
    logic [4:0] snt_q[$];
    logic rdy_en = 1'B1;
    int seed = 41;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    initial forever #2 MCLK = ~MCLK;

    trt_transmitter #(.UNIT_CYCLES(U), .STOP_UNITS(1), .FIFO_DEPTH(16)) i_dut (
        .MCLK(MCLK), .RESET(RESET), .START_REQ(START_REQ), .TAPE_OUT(TAPE_OUT),
        .TIGHT_TAPE(TIGHT_TAPE), .MANUAL_STOP(MANUAL_STOP), .TAPE_ROW(TAPE_ROW),
        .LINE_MARK(LINE_MARK), .TAPE_ADVANCE(TAPE_ADVANCE), .BUSY(BUSY),
        .SENT_VALID(SENT_VALID), .SENT_READY(SENT_READY), .SENT_CODE(SENT_CODE)
    );

    trt_line_rx #(.UNIT(U)) i_rx (
        .clk(MCLK), .rst(RESET), .line(LINE_MARK), .rx_valid(rx_valid),
        .rx_code(rx_code), .rx_ok(rx_ok), .in_code(in_code)
    );

    task automatic cmp_code(input string what, input logic [4:0] e, input logic [4:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic cmp_int(input string what, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            mismatches++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Tape reader model, consumer handshake and timeout
    // ------------------------------------------------------------------------
    // Rows on the sense pins are scrambled while code slots run, so a row
    // that is not held for the group shows up as a wrong code.
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (TAPE_ADVANCE === 1'B1 && tape_q.size() > 0) begin
            void'(tape_q.pop_front());
        end
        TAPE_OUT <= (tape_q.size() == 0);
        TAPE_ROW <= (in_code || tape_q.size() == 0) ? 5'($random(seed)) : tape_q[0];
        SENT_READY <= rdy_en & 1'($random(seed));
        if (cyc > 12000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    // ------------------------------------------------------------------------
    // Result watchers
    // ------------------------------------------------------------------------
    always @(posedge MCLK) begin
        if (rx_valid === 1'B1) begin
            cmp_bit("framing", 1'B1, rx_ok);
            if (exp_q.size() == 0) cmp_int("surplus group", 0, 1);
            else cmp_code("line code", exp_q.pop_front(), rx_code);
        end
        if (SENT_VALID === 1'B1 && SENT_READY === 1'B1) begin
            if (snt_q.size() == 0) cmp_int("surplus sent code", 0, 1);
            else cmp_code("sent code", snt_q.pop_front(), SENT_CODE);
        end
    end

    task automatic load(input int k);
        logic [4:0] r;
        repeat (k) begin
            r = 5'($random(seed));
            tape_q.push_back(r);
            exp_q.push_back(r);
            snt_q.push_back(r);
        end
    endtask

    task automatic wait_busy(input int limit);
        n = 0;
        while (BUSY !== 1'B1 && n < limit) begin
            @(negedge MCLK);
            n++;
        end
        cmp_bit("busy rise", 1'B1, BUSY);
    endtask

    task automatic wait_done(input int limit);
        n = 0;
        while ((BUSY !== 1'B0 || tape_q.size() > 0 || exp_q.size() > 0) && n < limit) begin
            @(negedge MCLK);
            n++;
        end
        cmp_int("groups left", 0, exp_q.size());
        cmp_bit("line at rest", 1'B1, LINE_MARK);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge MCLK);
        RESET <= 1'B0;
        load(1);
        repeat (20) begin
            @(negedge MCLK);
            cmp_bit("idle line", 1'B1, LINE_MARK);
        end
        $display("Test idle done");
        @(posedge MCLK);
        START_REQ <= 1'B1;
        wait_done(200);
        load(4);
        wait_busy(100);
        n = 0;
        while (BUSY === 1'B1 && n < 400) begin
            @(negedge MCLK);
            n++;
        end
        cmp_int("burst length", 4 * 7 * U, n);
        wait_done(50);
        $display("Test burst done");
        for (int k = 0; k < 3; k++) begin
            @(posedge MCLK);
            START_REQ <= 1'B0;
            load(2);
            @(posedge MCLK);
            START_REQ <= 1'B1;
            wait_busy(100);
            n = 0;
            while (TAPE_ADVANCE !== 1'B1 && n < 100) begin
                @(negedge MCLK);
                n++;
            end
            @(posedge MCLK);
            START_REQ <= (k != 0);
            TIGHT_TAPE <= (k == 1);
            MANUAL_STOP <= (k == 2);
            repeat (60) @(negedge MCLK);
            cmp_bit("stopped", 1'B0, BUSY);
            cmp_int("rows left", 1, tape_q.size());
            @(posedge MCLK);
            START_REQ <= 1'B1;
            TIGHT_TAPE <= 1'B0;
            MANUAL_STOP <= 1'B0;
            wait_done(200);
        end
        $display("Test stop causes done");
        // The buffer must start empty, or the count of waiting rows shifts by one.
        while (snt_q.size() > 0) begin
            @(negedge MCLK);
        end
        rdy_en = 1'B0;
        load(20);
        repeat (1300) @(negedge MCLK);
        cmp_bit("held by full buffer", 1'B0, BUSY);
        cmp_int("rows waiting", 3, tape_q.size());
        rdy_en = 1'B1;
        wait_done(1500);
        repeat (40) @(negedge MCLK);
        cmp_int("sent codes left", 0, snt_q.size());
        $display("Test buffer done");
        finish_test();
    end
endmodule // test_tape_reader_startstop_transmitter
